// >>> inc/tas_pkg.sv
package tas_pkg;

	// slave addresses picked by the strap, and the alert response address
	localparam logic [6:0] TAS_ADDR_LO  = 7'h18;
	localparam logic [6:0] TAS_ADDR_HI  = 7'h4E;
	localparam logic [6:0] TAS_ARA_ADDR = 7'h0C;

	// command codes reached over the two-wire link
	localparam logic [7:0] TAS_CMD_LOCAL_TEMP  = 8'h00;
	localparam logic [7:0] TAS_CMD_REMOTE_HI   = 8'h01;
	localparam logic [7:0] TAS_CMD_STATUS      = 8'h02;
	localparam logic [7:0] TAS_CMD_CONFIG      = 8'h03;
	localparam logic [7:0] TAS_CMD_LOCAL_HIGH  = 8'h05;
	localparam logic [7:0] TAS_CMD_REMOTE_HIGH = 8'h07;
	localparam logic [7:0] TAS_CMD_REMOTE_LOW  = 8'h08;
	localparam logic [7:0] TAS_CMD_REMOTE_LO   = 8'h10;
	localparam logic [7:0] TAS_CMD_REMOTE_CRIT = 8'h19;

	// status byte layout, and the mask bit of the config byte
	localparam int TAS_ST_BUSY  = 7;
	localparam int TAS_ST_LHIGH = 6;
	localparam int TAS_ST_RHIGH = 4;
	localparam int TAS_ST_RLOW  = 3;
	localparam int TAS_ST_OPEN  = 2;
	localparam int TAS_ST_RCRIT = 1;
	localparam logic [7:0] TAS_ST_ALERT_BITS = 8'h5A;
	localparam int TAS_CFG_MASK_BIT = 7;

	// widths of the readings
	localparam int TAS_REMOTE_W = 11;
	localparam int TAS_LOCAL_W  = 8;
	localparam int TAS_FRAC_W   = 3;
	localparam int TAS_PAD_W    = 5;

	// reset values, and the bit count of a byte
	localparam logic [7:0] TAS_RST_LOCAL_HIGH  = 8'h46;
	localparam logic [7:0] TAS_RST_REMOTE_HIGH = 8'h46;
	localparam logic [7:0] TAS_RST_REMOTE_LOW  = 8'h00;
	localparam logic [7:0] TAS_RST_REMOTE_CRIT = 8'h6E;
	localparam logic [3:0] TAS_BITS_PER_BYTE   = 4'h8;

	typedef struct packed {
		logic [7:0] local_high;
		logic [7:0] remote_high;
		logic [7:0] remote_low;
		logic [7:0] remote_crit;
	} tas_limits_s;

	typedef enum {
		TAS_IDLE,
		TAS_ADDR,
		TAS_AACK,
		TAS_TX,
		TAS_RACK,
		TAS_CMD,
		TAS_CACK,
		TAS_WDATA
	} tas_smb_state_e;

endpackage : tas_pkg

// >>> hdl/tas_sync.sv
`timescale 1ns/1ps
module tas_sync #(
	parameter int W = 3
) (
	input  wire logic         ref_clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	logic [W-1:0] stage1_r;

	// elaboration-time refusal of a width the flops cannot hold
	if (W < 1)
	begin : g_bad_width
		$error("tas_sync: width must be at least one");
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			stage1_r <= '1;
			sync_out <= '1;
		end
		else
		begin
			stage1_r <= async_in;
			sync_out <= stage1_r;
		end
	end
endmodule : tas_sync

// >>> hdl/tas_limit_cmp.sv
`timescale 1ns/1ps
module tas_limit_cmp (
	input  wire tas_pkg::tas_limits_s lim,
	input  wire logic [7:0]           local_temp,
	input  wire logic [10:0]          remote_temp,
	output logic [7:0]                hit
);
	import tas_pkg::*;

	// remote limits are whole degrees, compared on the 0.125 degree grid
	always_comb
	begin
		hit = 8'h00;
		hit[TAS_ST_LHIGH] = $signed(local_temp) > $signed(lim.local_high);
		hit[TAS_ST_RHIGH] = $signed(remote_temp) > $signed({lim.remote_high, 3'h0});
		hit[TAS_ST_RLOW]  = $signed(remote_temp) < $signed({lim.remote_low, 3'h0});
		hit[TAS_ST_RCRIT] = $signed(remote_temp) > $signed({lim.remote_crit, 3'h0});
	end
endmodule : tas_limit_cmp

// >>> hdl/tas_alert_smbus.sv
`timescale 1ns/1ps
module tas_alert_smbus (
	input  wire logic         ref_clk,
	input  wire logic         rst_n,
	input  wire logic         smb_clk_in,
	input  wire logic         smb_dat_in,
	output logic              smb_dat_out,
	output logic              smb_dat_oe_n,
	output logic              alert_out,
	output logic              alert_oe_n,
	input  wire logic         addr_select_input,
	input  wire logic         comp_mode,
	input  wire logic         alert_cfg,
	input  wire logic         conv_done,
	input  wire logic         conv_busy,
	input  wire logic         open_diode,
	input  wire logic [7:0]   local_temp_reading,
	input  wire logic [10:0]  remote_temp_in,
	output logic              alert_mask,
	output logic [7:0]        alert_status,
	output logic [15:0]       remote_word,
	output tas_pkg::tas_limits_s limits
);
	import tas_pkg::*;

	logic [2:0]     sync_w;
	logic           scl_s, sda_s, addr_sel_s;
	logic           scl_d_r, sda_d_r;
	logic           scl_rise, scl_fall, bus_start, bus_stop;
	logic [6:0]     own_addr;
	logic [7:0]     hit;

	tas_smb_state_e st_r, st_nxt;
	logic [3:0]     cnt_r, cnt_nxt;
	logic [7:0]     sh_r, sh_nxt, cmd_r, cmd_nxt, tx_r, tx_nxt;
	logic           rw_r, rw_nxt, ara_r, ara_nxt, oe_n_r, oe_n_nxt;
	logic           rd_status, wr_en, ara_done;
	logic [7:0]     rd_byte;

	logic [7:0]     status_r, status_nxt, cond_r, cond_nxt;
	logic           mask_r, mask_nxt, alert_n_r, alert_n_nxt;
	logic [7:0]     local_r, local_nxt;
	logic [10:0]    remote_r, remote_nxt;
	tas_limits_s    lim_r, lim_nxt;
	logic [7:0]     alert_src;

	tas_sync #(
		.W(3)
	) u_sync (
		.ref_clk  (ref_clk),
		.rst_n    (rst_n),
		.async_in ({smb_clk_in, smb_dat_in, addr_select_input}),
		.sync_out (sync_w)
	);

	assign scl_s = sync_w[2];
	assign sda_s = sync_w[1];
	assign addr_sel_s = sync_w[0];

	tas_limit_cmp u_cmp (
		.lim         (lim_r),
		.local_temp  (local_temp_reading),
		.remote_temp (remote_temp_in),
		.hit         (hit)
	);

	assign own_addr  = addr_sel_s ? TAS_ADDR_HI : TAS_ADDR_LO;
	assign scl_rise  = scl_s & ~scl_d_r;
	assign scl_fall  = ~scl_s & scl_d_r;
	assign bus_start = scl_s & scl_d_r & sda_d_r & ~sda_s;
	assign bus_stop  = scl_s & scl_d_r & ~sda_d_r & sda_s;

	// clock line is input only; data line is open-drain, low when enabled
	assign smb_dat_out  = 1'b0;
	assign smb_dat_oe_n = oe_n_r;
	assign alert_out    = 1'b0;
	assign alert_oe_n   = alert_n_r;
	assign alert_mask   = mask_r;
	assign alert_status = status_r;
	assign remote_word  = {remote_r, {TAS_PAD_W{1'b0}}};
	assign limits       = lim_r;

	// register read mux; readings have no write path
	always_comb
	begin
		rd_byte = 8'h00;
		if (cmd_r == TAS_CMD_LOCAL_TEMP)
			rd_byte = local_r;
		else if (cmd_r == TAS_CMD_REMOTE_HI)
			rd_byte = remote_r[10:3];
		else if (cmd_r == TAS_CMD_REMOTE_LO)
			rd_byte = {remote_r[2:0], {TAS_PAD_W{1'b0}}};
		else if (cmd_r == TAS_CMD_STATUS)
		begin
			rd_byte = status_r;
			rd_byte[TAS_ST_BUSY] = conv_busy;
			rd_byte[TAS_ST_OPEN] = open_diode;
		end
		else if (cmd_r == TAS_CMD_CONFIG)
			rd_byte = {mask_r, 7'h00};
		else if (cmd_r == TAS_CMD_LOCAL_HIGH)
			rd_byte = lim_r.local_high;
		else if (cmd_r == TAS_CMD_REMOTE_HIGH)
			rd_byte = lim_r.remote_high;
		else if (cmd_r == TAS_CMD_REMOTE_LOW)
			rd_byte = lim_r.remote_low;
		else if (cmd_r == TAS_CMD_REMOTE_CRIT)
			rd_byte = lim_r.remote_crit;
	end

	// link engine: samples data on clock rise, changes data on clock fall
	always_comb
	begin
		st_nxt    = st_r;
		cnt_nxt   = cnt_r;
		sh_nxt    = sh_r;
		cmd_nxt   = cmd_r;
		tx_nxt    = tx_r;
		rw_nxt    = rw_r;
		ara_nxt   = ara_r;
		oe_n_nxt  = oe_n_r;
		rd_status = 1'b0;
		wr_en     = 1'b0;
		ara_done  = 1'b0;
		if (bus_start)
		begin
			st_nxt   = TAS_ADDR;
			cnt_nxt  = 4'h0;
			ara_nxt  = 1'b0;
			oe_n_nxt = 1'b1;
		end
		else if (bus_stop)
		begin
			st_nxt   = TAS_IDLE;
			ara_nxt  = 1'b0;
			oe_n_nxt = 1'b1;
		end
		else
		begin
			case (st_r)
				TAS_ADDR, TAS_CMD, TAS_WDATA:
				begin
					if (scl_rise)
					begin
						sh_nxt  = {sh_r[6:0], sda_s};
						cnt_nxt = cnt_r + 4'h1;
					end
					else if (scl_fall && cnt_r == TAS_BITS_PER_BYTE)
					begin
						cnt_nxt  = 4'h0;
						oe_n_nxt = 1'b0;
						if (st_r == TAS_CMD)
						begin
							cmd_nxt = sh_r;
							st_nxt  = TAS_CACK;
						end
						else if (st_r == TAS_WDATA)
						begin
							wr_en  = 1'b1;
							st_nxt = TAS_CACK;
						end
						else if (sh_r[7:1] == own_addr)
						begin
							rw_nxt = sh_r[0];
							st_nxt = TAS_AACK;
						end
						else if (sh_r[7:1] == TAS_ARA_ADDR && sh_r[0] && !alert_n_r
							&& !alert_cfg)
						begin
							rw_nxt  = 1'b1;
							ara_nxt = 1'b1;
							st_nxt  = TAS_AACK;
						end
						else
						begin
							oe_n_nxt = 1'b1;
							st_nxt   = TAS_IDLE;
						end
					end
				end
				TAS_AACK:
				begin
					if (scl_fall)
					begin
						cnt_nxt = 4'h0;
						if (rw_r)
						begin
							tx_nxt    = ara_r ? {own_addr, 1'b0} : rd_byte;
							oe_n_nxt  = tx_nxt[7];
							rd_status = !ara_r && cmd_r == TAS_CMD_STATUS;
							st_nxt    = TAS_TX;
						end
						else
						begin
							oe_n_nxt = 1'b1;
							st_nxt   = TAS_CMD;
						end
					end
				end
				TAS_TX:
				begin
					if (scl_rise)
					begin
						cnt_nxt = cnt_r + 4'h1;
						if (ara_r && tx_r[7] && !sda_s)
						begin
							st_nxt   = TAS_IDLE;
							ara_nxt  = 1'b0;
							oe_n_nxt = 1'b1;
						end
					end
					else if (scl_fall)
					begin
						if (cnt_r == TAS_BITS_PER_BYTE)
						begin
							oe_n_nxt = 1'b1;
							ara_done = ara_r;
							ara_nxt  = 1'b0;
							st_nxt   = TAS_RACK;
						end
						else
						begin
							tx_nxt   = {tx_r[6:0], 1'b0};
							oe_n_nxt = tx_nxt[7];
						end
					end
				end
				TAS_RACK:
				begin
					if (scl_rise)
						st_nxt = sda_s ? TAS_IDLE : TAS_AACK;
				end
				TAS_CACK:
				begin
					if (scl_fall)
					begin
						oe_n_nxt = 1'b1;
						st_nxt   = TAS_WDATA;
					end
				end
				default:
				begin
					st_nxt = TAS_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
			st_r    <= TAS_IDLE;
			cnt_r   <= 4'h0;
			sh_r    <= 8'h00;
			cmd_r   <= 8'h00;
			tx_r    <= 8'h00;
			rw_r    <= 1'b0;
			ara_r   <= 1'b0;
			oe_n_r  <= 1'b1;
		end
		else
		begin
			scl_d_r <= scl_s;
			sda_d_r <= sda_s;
			st_r    <= st_nxt;
			cnt_r   <= cnt_nxt;
			sh_r    <= sh_nxt;
			cmd_r   <= cmd_nxt;
			tx_r    <= tx_nxt;
			rw_r    <= rw_nxt;
			ara_r   <= ara_nxt;
			oe_n_r  <= oe_n_nxt;
		end
	end

	// alert state: a conversion setting a bit wins over a clearing read
	always_comb
	begin
		status_nxt = (rd_status ? 8'h00 : status_r)
			| (conv_done ? (hit & TAS_ST_ALERT_BITS) : 8'h00);
		cond_nxt   = conv_done ? (hit & TAS_ST_ALERT_BITS) : cond_r;
		local_nxt  = conv_done ? local_temp_reading : local_r;
		remote_nxt = conv_done ? remote_temp_in : remote_r;
		lim_nxt    = lim_r;
		mask_nxt   = mask_r;
		if (wr_en)
		begin
			if (cmd_r == TAS_CMD_CONFIG)
				mask_nxt = sh_r[TAS_CFG_MASK_BIT];
			else if (cmd_r == TAS_CMD_LOCAL_HIGH)
				lim_nxt.local_high = sh_r;
			else if (cmd_r == TAS_CMD_REMOTE_HIGH)
				lim_nxt.remote_high = sh_r;
			else if (cmd_r == TAS_CMD_REMOTE_LOW)
				lim_nxt.remote_low = sh_r;
			else if (cmd_r == TAS_CMD_REMOTE_CRIT)
				lim_nxt.remote_crit = sh_r;
		end
		if ((rd_status && !comp_mode && |(status_r & TAS_ST_ALERT_BITS)) || ara_done)
			mask_nxt = 1'b1;
		alert_src   = comp_mode ? cond_r : status_r;
		alert_n_nxt = !(!mask_r && |(alert_src & TAS_ST_ALERT_BITS));
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			status_r  <= 8'h00;
			cond_r    <= 8'h00;
			local_r   <= 8'h00;
			remote_r  <= 11'h000;
			mask_r    <= 1'b0;
			alert_n_r <= 1'b1;
			lim_r     <= {TAS_RST_LOCAL_HIGH, TAS_RST_REMOTE_HIGH,
				TAS_RST_REMOTE_LOW, TAS_RST_REMOTE_CRIT};
		end
		else
		begin
			status_r  <= status_nxt;
			cond_r    <= cond_nxt;
			local_r   <= local_nxt;
			remote_r  <= remote_nxt;
			mask_r    <= mask_nxt;
			alert_n_r <= alert_n_nxt;
			lim_r     <= lim_nxt;
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	sequence s_addr_sent;
		(st_r == TAS_TX && ara_r && cnt_r == TAS_BITS_PER_BYTE) ##0 scl_fall;
	endsequence

	property p_conv_sets;
		conv_done && hit[TAS_ST_RHIGH] |=> status_r[TAS_ST_RHIGH];
	endproperty
	a_conv_sets: assert property (p_conv_sets)
		else $error("limit hit at conversion end not latched");

	property p_mask_blocks;
		mask_r |=> alert_oe_n;
	endproperty
	a_mask_blocks: assert property (p_mask_blocks)
		else $error("alert asserted while mask set");

	property p_cmp_release;
		comp_mode && (cond_r & TAS_ST_ALERT_BITS) == 8'h00 |=> alert_oe_n;
	endproperty
	a_cmp_release: assert property (p_cmp_release)
		else $error("comparator alert held after condition cleared");

	property p_int_read_masks;
		rd_status && !comp_mode && |(status_r & TAS_ST_ALERT_BITS) |=> mask_r ##1 alert_oe_n;
	endproperty
	a_int_read_masks: assert property (p_int_read_masks)
		else $error("status read did not mask and release alert");

	property p_read_clears;
		rd_status && !conv_done |=> status_r == 8'h00;
	endproperty
	a_read_clears: assert property (p_read_clears)
		else $error("status read did not clear status");

	property p_arb_loss;
		st_r == TAS_TX && ara_r && tx_r[7] && !sda_s && scl_rise && !bus_start && !bus_stop
			|=> smb_dat_oe_n && st_r == TAS_IDLE;
	endproperty
	a_arb_loss: assert property (p_arb_loss)
		else $error("kept sending after arbitration loss");

	property p_ara_done;
		s_addr_sent ##0 (!bus_start && !bus_stop) |=> mask_r ##1 alert_oe_n;
	endproperty
	a_ara_done: assert property (p_ara_done)
		else $error("alert not released after address sent");

	property p_ara_cfg;
		$rose(ara_r) |-> $past(alert_cfg) == 1'b0 && $past(alert_oe_n) == 1'b0;
	endproperty
	a_ara_cfg: assert property (p_ara_cfg)
		else $error("answered response address while not allowed");

	property p_own_addr;
		st_r == TAS_AACK && ara_r && scl_fall && !bus_start && !bus_stop
			|=> tx_r == {(addr_sel_s ? TAS_ADDR_HI : TAS_ADDR_LO), 1'b0};
	endproperty
	a_own_addr: assert property (p_own_addr)
		else $error("wrong own address sent");
endmodule : tas_alert_smbus

// >>> testbench/tas_host_model.sv
`timescale 1ns/1ps
module tas_host_model (
	input  wire logic ref_clk,
	input  wire logic dat_oe_n,
	output logic      smb_clk,
	output logic      smb_dat
);
	logic scl_r     = 1'b1;
	logic sda_r     = 1'b1;
	logic rival_low = 1'b0;
	// the data line is pulled up, so a low from any party wins; the clock is driven by the host alone
	assign smb_dat = sda_r & dat_oe_n & ~rival_low;
	assign smb_clk = scl_r;
	// a quarter of the 64 ns bit period
	task automatic q;
		repeat (2) @(negedge ref_clk);
	endtask : q
	// data moves only while the clock is low and is sampled mid-high
	task automatic xfer(input logic b, output logic s);
		sda_r = b;
		q;
		scl_r = 1'b1;
		q;
		s = smb_dat;
		q;
		scl_r = 1'b0;
		q;
	endtask : xfer
	task automatic start;
		sda_r = 1'b1;
		q;
		scl_r = 1'b1;
		q;
		sda_r = 1'b0;
		q;
		scl_r = 1'b0;
		q;
	endtask : start
	task automatic stop;
		sda_r = 1'b0;
		q;
		scl_r = 1'b1;
		q;
		sda_r = 1'b1;
		q;
	endtask : stop
	// msb first; the ninth bit is released, so a read always ends in a nack
	task automatic byte_io(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
		begin
			xfer(tx[i], rx[i]);
		end
		xfer(1'b1, s);
		ack = ~s;
	endtask : byte_io
endmodule : tas_host_model

// >>> testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import tas_pkg::*;
	logic        ref_clk = 1'b0;
	logic        rst_n   = 1'b0;
	logic        smb_clk;
	logic        smb_dat;
	logic        dat_out;
	logic        dat_oe_n;
	logic        alert_out;
	logic        alert_oe_n;
	logic        addr_sel    = 1'b0;
	logic        comp_mode   = 1'b0;
	logic        alert_cfg   = 1'b0;
	logic        conv_done   = 1'b0;
	logic        conv_busy   = 1'b0;
	logic        open_diode  = 1'b0;
	logic [7:0]  local_temp  = 8'h00;
	logic [10:0] remote_temp = 11'h000;
	logic        alert_mask;
	logic [7:0]  alert_status;
	logic [15:0] remote_word;
	tas_limits_s limits;
	logic [6:0]  own;
	logic [7:0]  rx;
	logic        ack;
	int          failures = 0;
	int          checked  = 0;
	int          cycles   = 0;
	tas_host_model host (.ref_clk(ref_clk), .dat_oe_n(dat_oe_n), .smb_clk(smb_clk),
		.smb_dat(smb_dat));
	tas_alert_smbus DUT (.ref_clk(ref_clk), .rst_n(rst_n), .smb_clk_in(smb_clk),
		.smb_dat_in(smb_dat), .smb_dat_out(dat_out), .smb_dat_oe_n(dat_oe_n),
		.alert_out(alert_out), .alert_oe_n(alert_oe_n), .addr_select_input(addr_sel),
		.comp_mode(comp_mode), .alert_cfg(alert_cfg), .conv_done(conv_done),
		.conv_busy(conv_busy), .open_diode(open_diode), .local_temp_reading(local_temp),
		.remote_temp_in(remote_temp), .alert_mask(alert_mask), .alert_status(alert_status),
		.remote_word(remote_word), .limits(limits));
	always #4 ref_clk = ~ref_clk;
	always @(posedge ref_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 60000)
		begin
			failures++;
			tally_and_finish;
		end
	end
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : tally_and_finish
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp)
		begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic wr(input logic [6:0] a, input logic [7:0] cmd, input logic [7:0] d,
		input logic exp_ack);
		host.start;
		host.byte_io({a, 1'b0}, rx, ack);
		chk("address ack", exp_ack, ack);
		if (ack)
		begin
			host.byte_io(cmd, rx, ack);
			host.byte_io(d, rx, ack);
		end
		host.stop;
		repeat (4) @(negedge ref_clk);
	endtask : wr
	task automatic rd(input logic [7:0] cmd, input logic [7:0] exp, input string what);
		host.start;
		host.byte_io({own, 1'b0}, rx, ack);
		host.byte_io(cmd, rx, ack);
		host.start;
		host.byte_io({own, 1'b1}, rx, ack);
		host.byte_io(8'hFF, rx, ack);
		host.stop;
		chk(what, exp, rx);
		repeat (4) @(negedge ref_clk);
	endtask : rd
	task automatic ara(input logic rival);
		logic nack;
		host.start;
		host.byte_io({TAS_ARA_ADDR, 1'b1}, rx, ack);
		if (ack)
		begin
			host.rival_low = rival;
			host.byte_io(8'hFF, rx, nack);
			host.rival_low = 1'b0;
		end
		host.stop;
		repeat (4) @(negedge ref_clk);
	endtask : ara
	task automatic conv(input logic [7:0] lcl, input logic [10:0] rmt);
		@(negedge ref_clk);
		local_temp  = lcl;
		remote_temp = rmt;
		conv_done   = 1'b1;
		@(negedge ref_clk);
		conv_done = 1'b0;
		repeat (3) @(negedge ref_clk);
	endtask : conv
	task automatic t_reset;
		chk("limits", {8'h46, 8'h46, 8'h00, 8'h6E}, limits);
		chk("mask", 0, alert_mask);
		chk("status", 0, alert_status);
		chk("alert", 1, alert_oe_n);
		chk("alert level", 0, alert_out);
		chk("data level", 0, dat_out);
	endtask : t_reset
	task automatic t_addr;
		for (int s = 0; s < 2; s++)
		begin
			addr_sel = s[0];
			own = s[0] ? TAS_ADDR_HI : TAS_ADDR_LO;
			wr(TAS_ADDR_LO, TAS_CMD_LOCAL_HIGH, 8'h20 + 8'(s), !s[0]);
			wr(TAS_ADDR_HI, TAS_CMD_LOCAL_HIGH, 8'h20 + 8'(s), s[0]);
		end
		chk("local high", 8'h21, limits.local_high);
		rd(TAS_CMD_LOCAL_HIGH, 8'h21, "local high read");
	endtask : t_addr
	task automatic t_limits;
		logic [7:0] cmds [3] = '{TAS_CMD_REMOTE_HIGH, TAS_CMD_REMOTE_LOW, TAS_CMD_REMOTE_CRIT};
		logic [7:0] dflt [3] = '{TAS_RST_REMOTE_HIGH, TAS_RST_REMOTE_LOW, TAS_RST_REMOTE_CRIT};
		for (int i = 0; i < 3; i++)
		begin
			wr(own, cmds[i], 8'h5A + 8'(i), 1'b1);
			rd(cmds[i], 8'h5A + 8'(i), "limit read back");
		end
		chk("limits", {8'h21, 8'h5A, 8'h5B, 8'h5C}, limits);
		for (int i = 0; i < 3; i++)
		begin
			wr(own, cmds[i], dflt[i], 1'b1);
		end
		rd(TAS_CMD_CONFIG, 8'h00, "config read");
	endtask : t_limits
	task automatic t_format;
		conv_busy  = 1'b1;
		open_diode = 1'b1;
		conv(8'hE7, 11'h0A1);
		chk("word", 16'h1420, remote_word);
		chk("alert", 1, alert_oe_n);
		rd(TAS_CMD_REMOTE_HI, 8'h14, "remote high byte");
		rd(TAS_CMD_REMOTE_LO, 8'h20, "remote low byte");
		wr(own, TAS_CMD_LOCAL_TEMP, 8'h55, 1'b1);
		rd(TAS_CMD_LOCAL_TEMP, 8'hE7, "local reading");
		rd(TAS_CMD_STATUS, 8'h84, "busy and open");
		chk("mask", 0, alert_mask);
		conv_busy  = 1'b0;
		open_diode = 1'b0;
	endtask : t_format
	task automatic t_intr;
		logic [7:0]  lcl [3] = '{8'h22, 8'h10, 8'h10};
		logic [10:0] rmt [3] = '{11'h0A1, 11'h7F8, 11'h378};
		logic [7:0]  st [3] = '{8'h40, 8'h08, 8'h12};
		for (int i = 0; i < 3; i++)
		begin
			conv(lcl[i], rmt[i]);
			chk("status", st[i], alert_status);
			chk("alert", 0, alert_oe_n);
			rd(TAS_CMD_STATUS, st[i], "status read");
			chk("status cleared", 0, alert_status);
			chk("mask", 1, alert_mask);
			chk("alert", 1, alert_oe_n);
			wr(own, TAS_CMD_CONFIG, 8'h00, 1'b1);
			chk("mask", 0, alert_mask);
		end
		wr(own, TAS_CMD_CONFIG, 8'h80, 1'b1);
		conv(8'h22, 11'h0A1);
		chk("masked alert", 1, alert_oe_n);
		rd(TAS_CMD_CONFIG, 8'h80, "config read");
		wr(own, TAS_CMD_CONFIG, 8'h00, 1'b1);
		chk("alert", 0, alert_oe_n);
	endtask : t_intr
	task automatic t_comp;
		comp_mode = 1'b1;
		rd(TAS_CMD_STATUS, 8'h40, "status read");
		chk("comparator mask", 0, alert_mask);
		wr(own, TAS_CMD_CONFIG, 8'h00, 1'b1);
		conv(8'h22, 11'h0A1);
		chk("comparator alert", 0, alert_oe_n);
		conv(8'h10, 11'h0A1);
		chk("comparator release", 1, alert_oe_n);
		comp_mode = 1'b0;
		repeat (3) @(negedge ref_clk);
		chk("interrupt alert", 0, alert_oe_n);
	endtask : t_comp
	task automatic t_ara;
		alert_cfg = 1'b1;
		ara(1'b0);
		chk("ara refused", 0, ack);
		alert_cfg = 1'b0;
		ara(1'b1);
		chk("ara ack", 1, ack);
		chk("lost mask", 0, alert_mask);
		chk("lost alert", 0, alert_oe_n);
		ara(1'b0);
		chk("ara ack", 1, ack);
		chk("ara byte", {own, 1'b0}, rx);
		chk("mask", 1, alert_mask);
		chk("alert", 1, alert_oe_n);
		ara(1'b0);
		chk("ara idle", 0, ack);
	endtask : t_ara
	initial
	begin
		repeat (8) @(negedge ref_clk);
		rst_n = 1'b1;
		repeat (4) @(negedge ref_clk);
		t_reset;
		t_addr;
		t_limits;
		t_format;
		t_intr;
		t_comp;
		t_ara;
		tally_and_finish;
	end
endmodule : tb_top
